// *** asp_host_model.sv ***
`timescale 1ns/1ps
module asp_host_model (
    // clock and run control
    input  wire logic        i_clk_sys,
    input  wire logic        i_run,
    // resolved pins
    input  wire logic        i_bclk,
    input  wire logic        i_fs,
    input  wire logic        i_sdata,
    // host side drive
    output logic             o_bclk,
    output logic             o_fs,
    // captured phases, frame length and frame count
    output logic      [31:0] o_ph_hi,
    output logic      [31:0] o_ph_lo,
    output logic      [9:0]  o_flen,
    output logic      [15:0] o_frames
);
    logic [1:0]  div;
    logic [4:0]  bit_cnt;
    logic [9:0]  cnt;
    logic [31:0] sh;
    logic        b_q;
    logic        f_q;

    initial
    begin
        {div, bit_cnt, cnt, sh, b_q, f_q, o_bclk, o_fs} = '0;
        {o_ph_hi, o_ph_lo, o_flen, o_frames} = '0;
    end

    // bit clock stands still unless a frame run is requested
    always @(posedge i_clk_sys)
    begin
        if (i_run)
        begin
            div <= div + 2'h1;
            if (div == 2'h3)
            begin
                o_bclk <= ~o_bclk;
                if (o_bclk)
                begin
                    bit_cnt <= bit_cnt + 5'h1;
                    if (bit_cnt == 5'h1f)
                        o_fs <= ~o_fs;
                end
            end
        end
    end

    // sample data and sync on each bit clock rise
    always @(posedge i_clk_sys)
    begin
        b_q <= i_bclk;
        if (i_bclk && !b_q)
        begin
            f_q <= i_fs;
            sh <= {sh[30:0], i_sdata};
            cnt <= cnt + 10'h1;
            if (i_fs != f_q)
            begin
                if (f_q)
                    o_ph_hi <= sh;
                else
                    o_ph_lo <= sh;
            end
            if (i_fs && !f_q)
            begin
                o_flen <= cnt;
                cnt <= 10'h1;
                o_frames <= o_frames + 16'h1;
            end
        end
    end
endmodule // asp_host_model

// *** asp_params.svh ***
`ifndef ASP_PARAMS_SVH
`define ASP_PARAMS_SVH

// register offsets
`define ASP_REG_IFACE    7'h07
`define ASP_REG_COMP     7'h25
`define ASP_REG_FRAME    7'h26
`define ASP_REG_STAT     7'h27
`define ASP_REG_TSL      7'h5b
`define ASP_REG_TSCTL    7'h5c
`define ASP_REG_TSR      7'h5d

// interface control fields
`define ASP_MS_BIT       6
`define ASP_FSP_BIT      4
`define ASP_WORD_LENGTH_SEL_LO      2
`define ASP_FMT_LO       0

// time-slot control fields
`define ASP_TSEN_BIT     8
`define ASP_TRI_BIT      7
`define ASP_B8_BIT       5
`define ASP_OESEL_BIT    2
`define ASP_TSL_HI_BIT   1
`define ASP_TSR_HI_BIT   0

// companding and frame fields
`define ASP_COMP_LO      1
`define ASP_FLEN_LO      0
`define ASP_IDLE_LO      4

// reset values
`define ASP_RST_IFACE    9'h000
`define ASP_RST_COMP     9'h000
`define ASP_RST_FRAME    9'h000
`define ASP_RST_TSL      9'h000
`define ASP_RST_TSCTL    9'h000
`define ASP_RST_TSR      9'h000

// bit clock half period in system clocks when driving the link
`define ASP_BCLK_HALF_DIV 2

`endif

// *** asp_pkg.sv ***
package asp_pkg;

    typedef enum logic [1:0] {
        ASP_IDLE  = 2'b00,
        ASP_DRIVE = 2'b01,
        ASP_HOLD  = 2'b11
    } asp_state_t;

    typedef enum logic [1:0] {
        ASP_FMT_RJ  = 2'b00,
        ASP_FMT_LJ  = 2'b01,
        ASP_FMT_I2S = 2'b10,
        ASP_FMT_PCM = 2'b11
    } asp_fmt_t;

    typedef enum logic [1:0] {
        ASP_COMP_OFF  = 2'b00,
        ASP_COMP_RSVD = 2'b01,
        ASP_COMP_MU   = 2'b10,
        ASP_COMP_A    = 2'b11
    } asp_comp_t;

    typedef enum logic [2:0] {
        ASP_IDLE_HIZ = 3'h0,
        ASP_IDLE_PD  = 3'h1,
        ASP_IDLE_PU  = 3'h2,
        ASP_IDLE_LO  = 3'h3,
        ASP_IDLE_HI  = 3'h4
    } asp_idle_t;

endpackage

// *** asp_serial_port.sv ***
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "asp_params.svh"

module asp_serial_port #(
    parameter int unsigned HALF_DIV = `ASP_BCLK_HALF_DIV
) (
    // clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_arst_n,
    // register port
    input  wire logic [6:0]  i_addr,
    input  wire logic [8:0]  i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [8:0]  o_rdata,
    // samples from the converter
    input  wire logic [23:0] i_left,
    input  wire logic [23:0] i_right,
    input  wire logic        i_sample_stb,
    // bit clock pin
    input  wire logic        i_bclk,
    output logic             o_bclk,
    output logic             o_bclk_oe,
    // frame sync pin
    input  wire logic        i_fs,
    output logic             o_fs,
    output logic             o_fs_oe,
    // serial audio out pin
    output logic             o_sdata,
    output logic             o_sdata_oe,
    output logic             o_sdata_pull_up,
    output logic             o_sdata_pull_dn
);
    import asp_pkg::*;

    logic [1:0]  rst_sync;
    logic        rst_n;
    logic [8:0]  iface;
    logic [8:0]  comp;
    logic [8:0]  frame;
    logic [8:0]  tsl;
    logic [8:0]  tsctl;
    logic [8:0]  tsr;
    logic        master_select;
    logic        frame_sync_polarity;
    logic        timeslot_enable;
    logic        tri_timing;
    logic        byte_word_override;
    logic        out_enable_select;
    logic [1:0]  word_length_sel;
    logic [9:0]  left_slot_start;
    logic [9:0]  right_slot_start;
    asp_fmt_t    fmt;
    asp_comp_t   comp_sel;
    asp_idle_t   idle_sel;
    logic [9:0]  flen;
    logic [9:0]  half;
    logic [5:0]  wbits;
    logic [7:0]  div_cnt;
    logic        tick;
    logic        bclk_prev;
    logic        rise_ev;
    logic        fall_ev;
    logic [9:0]  mcnt;
    logic [9:0]  next_mcnt;
    logic        next_mfs;
    logic        fs_new;
    logic        fs_last;
    logic        fs_chg;
    logic        fs_rose;
    logic [9:0]  hc;
    logic [9:0]  fc;
    logic [9:0]  next_hc;
    logic [9:0]  next_fc;
    logic        load_ev;
    logic [23:0] buf_l;
    logic [23:0] buf_r;
    logic        pend;
    logic [31:0] lword;
    logic [31:0] rword;
    logic [31:0] wl_cur;
    logic [31:0] wr_cur;
    logic        chan;
    logic        win;
    logic [9:0]  pos;
    logic [10:0] start;
    logic [10:0] sl;
    logic [10:0] sr;
    logic [4:0]  bidx;
    logic [4:0]  bidx_q;
    logic        bitv;
    asp_state_t  st;
    asp_state_t  next_st;
    logic        next_bit;
    logic        dbit;

    function automatic logic [9:0] frame_len(input logic [2:0] s);
        case (s)
            3'h1:    frame_len = 10'h080;
            3'h2:    frame_len = 10'h040;
            3'h3:    frame_len = 10'h020;
            3'h4:    frame_len = 10'h0c0;
            default: frame_len = 10'h100;
        endcase
    endfunction

    function automatic logic [5:0] word_bits(input logic [1:0] w, input logic b8);
        if (b8)
            word_bits = 6'h08;
        else
            case (w)
                2'b00:   word_bits = 6'h10;
                2'b01:   word_bits = 6'h14;
                2'b10:   word_bits = 6'h18;
                default: word_bits = 6'h20;
            endcase
    endfunction

    function automatic logic in_win(input logic [9:0] p, input logic [10:0] s,
                                    input logic [5:0] w);
        in_win = ({1'b0, p} >= s) && (({1'b0, p} - s) < {5'h00, w});
    endfunction

    // 13-bit linear to mu-law byte
    function automatic logic [7:0] mu_enc(input logic [12:0] s);
        logic [11:0] mag;
        logic [12:0] bias;
        logic [2:0]  ex;
        logic [3:0]  mt;
        mag  = s[12] ? ~s[11:0] : s[11:0];
        bias = {1'b0, mag} + 13'h0021;
        if (bias[12])
            bias = 13'h0fff;
        ex = 3'h0;
        for (int i = 1; i < 8; i++)
            if (bias[i+5])
                ex = 3'(i);
        mt = 4'(bias >> ({1'b0, ex} + 4'h1));
        mu_enc = ~{s[12], ex, mt};
    endfunction

    // 12-bit linear to A-law byte
    function automatic logic [7:0] al_enc(input logic [11:0] s);
        logic [10:0] mag;
        logic [2:0]  ex;
        logic [3:0]  mt;
        mag = s[11] ? ~s[10:0] : s[10:0];
        ex  = 3'h0;
        for (int i = 1; i < 8; i++)
            if (mag[i+3])
                ex = 3'(i);
        mt = (ex == 3'h0) ? mag[3:0] : 4'(mag >> ({1'b0, ex} - 4'h1));
        al_enc = {~s[11], ex, mt} ^ 8'h55;
    endfunction

    function automatic logic [31:0] to_word(input logic [23:0] x, input asp_comp_t c);
        case (c)
            ASP_COMP_MU: to_word = {mu_enc(x[23:11]), 24'h000000};
            ASP_COMP_A:  to_word = {al_enc(x[23:12]), 24'h000000};
            default:     to_word = {x, 8'h00};
        endcase
    endfunction

    // reset release
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
            rst_sync <= 2'b00;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end
    assign rst_n = rst_sync[1];

    // register writes
    always_ff @(posedge i_clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            iface <= `ASP_RST_IFACE;
            comp  <= `ASP_RST_COMP;
            frame <= `ASP_RST_FRAME;
            tsl   <= `ASP_RST_TSL;
            tsctl <= `ASP_RST_TSCTL;
            tsr   <= `ASP_RST_TSR;
        end
        else if (i_wr)
        begin
            case (i_addr)
                `ASP_REG_IFACE: iface <= i_wdata;
                `ASP_REG_COMP:  comp  <= i_wdata;
                `ASP_REG_FRAME: frame <= i_wdata;
                `ASP_REG_TSL:   tsl   <= i_wdata;
                `ASP_REG_TSCTL: tsctl <= i_wdata;
                `ASP_REG_TSR:   tsr   <= i_wdata;
                default:        ;
            endcase
        end
    end

    // register reads, data valid only the cycle after the strobe
    always_ff @(posedge i_clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            o_rdata <= 9'h000;
        else if (i_rd)
        begin
            case (i_addr)
                `ASP_REG_IFACE: o_rdata <= iface;
                `ASP_REG_COMP:  o_rdata <= comp;
                `ASP_REG_FRAME: o_rdata <= frame;
                `ASP_REG_TSL:   o_rdata <= tsl;
                `ASP_REG_TSCTL: o_rdata <= tsctl;
                `ASP_REG_TSR:   o_rdata <= tsr;
                `ASP_REG_STAT:  o_rdata <= {5'h00, st, fs_last, pend};
                default:        o_rdata <= 9'h000;
            endcase
        end
        else
            o_rdata <= 9'h000;
    end

    assign master_select       = iface[`ASP_MS_BIT];
    assign frame_sync_polarity = iface[`ASP_FSP_BIT];
    assign word_length_sel     = iface[`ASP_WORD_LENGTH_SEL_LO +: 2];
    assign fmt                 = asp_fmt_t'(iface[`ASP_FMT_LO +: 2]);
    assign timeslot_enable     = tsctl[`ASP_TSEN_BIT];
    assign tri_timing          = tsctl[`ASP_TRI_BIT];
    assign byte_word_override  = tsctl[`ASP_B8_BIT];
    assign out_enable_select   = tsctl[`ASP_OESEL_BIT];
    assign left_slot_start     = {tsctl[`ASP_TSL_HI_BIT], tsl};
    assign right_slot_start    = {tsctl[`ASP_TSR_HI_BIT], tsr};
    assign comp_sel            = asp_comp_t'(comp[`ASP_COMP_LO +: 2]);
    assign idle_sel            = asp_idle_t'(frame[`ASP_IDLE_LO +: 3]);
    assign flen                = frame_len(frame[`ASP_FLEN_LO +: 3]);
    assign half                = flen >> 1;
    assign wbits               = word_bits(word_length_sel, byte_word_override);

    // bit clock generation and edge events
    assign tick    = (div_cnt == 8'(HALF_DIV - 1));
    assign rise_ev = master_select ? (tick & ~o_bclk) : (i_bclk & ~bclk_prev);
    assign fall_ev = master_select ? (tick & o_bclk) : (~i_bclk & bclk_prev);

    always_ff @(posedge i_clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            div_cnt <= 8'h00;
            o_bclk  <= 1'b0;
        end
        else if (!master_select)
        begin
            div_cnt <= 8'h00;
            o_bclk  <= 1'b0;
        end
        else if (tick)
        begin
            div_cnt <= 8'h00;
            o_bclk  <= ~o_bclk;
        end
        else
            div_cnt <= div_cnt + 8'h01;
    end

    always_ff @(posedge i_clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bclk_prev <= 1'b0;
            o_bclk_oe <= 1'b0;
            o_fs_oe   <= 1'b0;
        end
        else
        begin
            bclk_prev <= i_bclk;
            o_bclk_oe <= master_select;
            o_fs_oe   <= master_select;
        end
    end

    // master frame counter and sync generation
    assign next_mcnt = (mcnt >= flen - 10'h001) ? 10'h000 : mcnt + 10'h001;

    always_comb
    begin
        case (fmt)
            ASP_FMT_PCM: next_mfs = (next_mcnt == 10'h000);
            ASP_FMT_I2S: next_mfs = (next_mcnt >= half);
            default:     next_mfs = (next_mcnt < half);
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mcnt <= 10'h000;
            o_fs <= 1'b0;
        end
        else if (!master_select)
        begin
            mcnt <= 10'h000;
            o_fs <= 1'b0;
        end
        else if (fall_ev)
        begin
            mcnt <= next_mcnt;
            o_fs <= next_mfs;
        end
    end

    // position counters since the last sync edge and since sync rise
    assign fs_new  = master_select ? next_mfs : i_fs;
    assign fs_chg  = fs_new ^ fs_last;
    assign fs_rose = fs_new & ~fs_last;
    assign next_hc = fs_chg ? 10'h000 : ((hc == 10'h3ff) ? hc : hc + 10'h001);
    assign next_fc = fs_rose ? 10'h000 : ((fc == 10'h3ff) ? fc : fc + 10'h001);
    assign load_ev = fall_ev & fs_chg & ((fmt == ASP_FMT_I2S) ? ~fs_new : fs_new);

    always_ff @(posedge i_clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fs_last <= 1'b0;
            hc      <= 10'h3ff;
            fc      <= 10'h3ff;
        end
        else if (fall_ev)
        begin
            fs_last <= fs_new;
            hc      <= next_hc;
            fc      <= next_fc;
        end
    end

    // sample capture at the converter rate, loaded at frame start
    always_ff @(posedge i_clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            buf_l <= 24'h000000;
            buf_r <= 24'h000000;
            pend  <= 1'b0;
            lword <= 32'h00000000;
            rword <= 32'h00000000;
        end
        else
        begin
            if (i_sample_stb)
            begin
                buf_l <= i_left;
                buf_r <= i_right;
            end
            if (i_sample_stb)
                pend <= 1'b1;
            else if (load_ev)
                pend <= 1'b0;
            if (load_ev)
            begin
                lword <= wl_cur;
                rword <= wr_cur;
            end
        end
    end

    assign wl_cur = load_ev ? to_word(buf_l, comp_sel) : lword;
    assign wr_cur = load_ev ? to_word(buf_r, comp_sel) : rword;

    // slot window and bit selection for the coming rising edge
    always_comb
    begin
        chan  = 1'b0;
        pos   = next_hc;
        start = 11'h000;
        sl    = 11'h000;
        sr    = 11'h000;
        case (fmt)
            ASP_FMT_RJ:
            begin
                chan  = ~fs_new;
                start = {1'b0, half} - {5'h00, wbits};
            end
            ASP_FMT_LJ:
            begin
                chan  = ~fs_new;
                start = 11'h000;
            end
            ASP_FMT_I2S:
            begin
                chan  = fs_new;
                start = 11'h001;
            end
            default:
            begin
                pos = next_fc;
                if (timeslot_enable)
                begin
                    sl = {1'b0, left_slot_start};
                    sr = {1'b0, right_slot_start};
                end
                else
                begin
                    sl = frame_sync_polarity ? 11'h000 : 11'h001;
                    sr = sl + {5'h00, wbits};
                end
                if (in_win(next_fc, sl, wbits))
                begin
                    chan  = 1'b0;
                    start = sl;
                end
                else
                begin
                    chan  = 1'b1;
                    start = sr;
                end
            end
        endcase
        win  = in_win(pos, start, wbits);
        bidx = 5'({1'b0, pos} - start);
        bitv = chan ? wr_cur[5'h1f - bidx] : wl_cur[5'h1f - bidx];
    end

    // pin driver state
    always_comb
    begin
        next_st  = st;
        next_bit = dbit;
        if (fall_ev)
        begin
            if (win)
            begin
                next_st  = ASP_DRIVE;
                next_bit = bitv;
            end
            else if (st == ASP_DRIVE && out_enable_select && !tri_timing)
                next_st = ASP_HOLD;
            else
                next_st = ASP_IDLE;
        end
        else if (rise_ev && st == ASP_HOLD)
            next_st = ASP_IDLE;
    end

    always_ff @(posedge i_clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st              <= ASP_IDLE;
            dbit            <= 1'b0;
            bidx_q          <= 5'h00;
            o_sdata         <= 1'b0;
            o_sdata_oe      <= 1'b0;
            o_sdata_pull_up <= 1'b0;
            o_sdata_pull_dn <= 1'b0;
        end
        else
        begin
            st   <= next_st;
            dbit <= next_bit;
            if (fall_ev && win)
                bidx_q <= bidx;
            o_sdata <= (next_st != ASP_IDLE) ? next_bit : (idle_sel == ASP_IDLE_HI);
            o_sdata_oe <= (next_st != ASP_IDLE) || (idle_sel == ASP_IDLE_LO)
                          || (idle_sel == ASP_IDLE_HI);
            o_sdata_pull_up <= (next_st == ASP_IDLE) && (idle_sel == ASP_IDLE_PU);
            o_sdata_pull_dn <= (next_st == ASP_IDLE) && (idle_sel == ASP_IDLE_PD);
        end
    end

    master_pins_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
        master_select && $past(master_select) |=> o_bclk_oe && o_fs_oe)
        else $error("master mode does not drive clock pins");

    frame_len_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
        master_select && $past(master_select) && $past(fall_ev) && $stable(frame)
        |-> mcnt < flen)
        else $error("master frame counter beyond frame length");

    idle_hiz_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
        st == ASP_IDLE && idle_sel == ASP_IDLE_HIZ && !fall_ev |=> !o_sdata_oe)
        else $error("idle pin driven in hi-z setting");

    lj_msb_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
        fall_ev && fmt == ASP_FMT_LJ && fs_chg
        |=> st == ASP_DRIVE && o_sdata == ($past(fs_new) ? lword[31] : rword[31]))
        else $error("left-justified MSB not presented after sync edge");

    pcm_sync_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
        master_select && fall_ev && fmt == ASP_FMT_PCM && mcnt == flen - 10'h001
        |=> o_fs ##1 (o_fs || fall_ev))
        else $error("PCM frame sync not raised at frame start");

    slot_start_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
        fall_ev && fmt == ASP_FMT_PCM && timeslot_enable && next_fc == left_slot_start
        |=> st == ASP_DRIVE && bidx_q == 5'h00)
        else $error("left slot MSB not at programmed count");

    byte_word_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
        byte_word_override && $past(byte_word_override) && st == ASP_DRIVE
        && $past(fall_ev) |-> bidx_q < 5'h08)
        else $error("word longer than eight bits under override");

    release_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
        st == ASP_HOLD && rise_ev |=> st == ASP_IDLE)
        else $error("data pin not released after LSB");

    rdata_pulse_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
        !i_rd |=> o_rdata == 9'h000)
        else $error("read data present without read strobe");

endmodule // asp_serial_port

// *** asp_serial_port_bench.sv ***
`timescale 1ns/1ps
module asp_serial_port_bench;
    localparam logic [23:0] smp_l = 24'hc35a81;
    localparam logic [23:0] smp_r = 24'h3c96e7;
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic [6:0]  addr = 7'h00;
    logic [8:0]  wdata = 9'h000;
    logic        wr_s = 1'b0;
    logic        rd_s = 1'b0;
    logic        stb = 1'b0;
    logic        run = 1'b0;
    logic        sd_last = 1'b0;
    logic [8:0]  rdata, rv;
    logic        bclk_o, bclk_oe, fs_o, fs_oe, sd_o, sd_oe, pu, pd, h_bclk, h_fs;
    logic [31:0] ph_hi, ph_lo;
    logic [9:0]  flen;
    logic [15:0] frames;
    logic [6:0]  regs[6] = '{7'h07, 7'h25, 7'h26, 7'h5b, 7'h5c, 7'h5d};
    int          lens[5] = '{256, 128, 64, 32, 192};
    int          n_fail = 0;
    int          n_tests = 0;
    int          cyc = 0;
    wire         bclk_pin = bclk_oe ? bclk_o : h_bclk;
    wire         fs_pin = fs_oe ? fs_o : h_fs;
    wire         sd_pin = sd_oe ? sd_o : (pu ? 1'b1 : (pd ? 1'b0 : ~sd_last));

    always #12.5 clk = ~clk;

    asp_serial_port #(.HALF_DIV(2)) u_dut (
        .i_clk_sys(clk), .i_arst_n(arst_n), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .i_left(smp_l), .i_right(smp_r),
        .i_sample_stb(stb), .i_bclk(bclk_pin), .o_bclk(bclk_o), .o_bclk_oe(bclk_oe),
        .i_fs(fs_pin), .o_fs(fs_o), .o_fs_oe(fs_oe), .o_sdata(sd_o),
        .o_sdata_oe(sd_oe), .o_sdata_pull_up(pu), .o_sdata_pull_dn(pd));

    asp_host_model u_host (
        .i_clk_sys(clk), .i_run(run), .i_bclk(bclk_pin), .i_fs(fs_pin), .i_sdata(sd_pin),
        .o_bclk(h_bclk), .o_fs(h_fs), .o_ph_hi(ph_hi), .o_ph_lo(ph_lo), .o_flen(flen),
        .o_frames(frames));

    task automatic final_report();
        $display("tests %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // sample strobe, released pin memory, hang guard
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        stb <= (cyc % 64 == 0);
        sd_last <= sd_pin;
        if (cyc == 60000)
        begin
            n_fail++;
            $display("Error %0t: timeout", $time);
            final_report();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic reg_wr(input logic [6:0] a, input logic [8:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask

    task automatic reg_rd(input logic [6:0] a, output logic [8:0] d);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic frames_wait(input int n);
        logic [15:0] f0;
        f0 = frames;
        while (frames < f0 + 16'(n))
            @(posedge clk);
    endtask

    // expected phase: word of n bits at slot s, idle level iv elsewhere
    function automatic logic [31:0] win(int s, int n, logic [23:0] w, logic iv);
        logic [31:0] m;
        m = ~(32'hffffffff >> n) >> s;
        return (({w, 8'h00} >> s) & m) | (iv ? ~m : 32'h0);
    endfunction

    task automatic fmt(input logic [8:0] ifc, input logic [8:0] ts, input logic [8:0] fr,
                       input logic [31:0] eh, input logic [31:0] el);
        reg_wr(7'h07, ifc);
        reg_wr(7'h5c, ts);
        reg_wr(7'h26, fr);
        frames_wait(4);
        @(negedge clk);
        check(ph_hi, eh);
        check(ph_lo, el);
        $display("test done: iface %h slot ctl %h idle %h", ifc, ts, fr);
    endtask

    initial
    begin
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        @(negedge clk);
        check(32'({sd_oe, pu, pd}), 32'h0);
        foreach (regs[i])
        begin
            reg_rd(regs[i], rv);
            check(32'(rv), 32'h0);
        end
        reg_rd(7'h10, rv);
        check(32'(rv), 32'h0);
        reg_wr(7'h25, 9'h004);
        reg_rd(7'h25, rv);
        check(32'(rv), 32'h4);
        reg_wr(7'h25, 9'h000);
        $display("test done: registers");
        reg_wr(7'h07, 9'h041);
        for (int i = 0; i < 5; i++)
        begin
            reg_wr(7'h26, 9'(i));
            frames_wait(3);
            check(32'(flen), 32'(lens[i]));
        end
        check(32'({bclk_oe, fs_oe}), 32'h3);
        $display("test done: master frame lengths");
        fmt(9'h041, 9'h000, 9'h042, win(0, 16, smp_l, 1), win(0, 16, smp_r, 1));
        fmt(9'h042, 9'h000, 9'h022, win(1, 16, smp_r, 1), win(1, 16, smp_l, 1));
        fmt(9'h040, 9'h000, 9'h012, win(16, 16, smp_l, 0), win(16, 16, smp_r, 0));
        fmt(9'h053, 9'h000, 9'h032, 32'h00000001, 32'h00000000);
        run <= 1'b1;
        reg_wr(7'h5b, 9'h003);
        reg_wr(7'h5d, 9'h028);
        fmt(9'h013, 9'h000, 9'h042, win(0, 16, smp_l, 1) & win(16, 16, smp_r, 1),
            32'hffffffff);
        fmt(9'h003, 9'h000, 9'h042, win(1, 16, smp_l, 1) & win(17, 16, smp_r, 1),
            32'h7fffffff);
        fmt(9'h003, 9'h100, 9'h042, win(3, 16, smp_l, 1), win(8, 16, smp_r, 1));
        fmt(9'h003, 9'h120, 9'h042, win(3, 8, smp_l, 1), win(8, 8, smp_r, 1));
        fmt(9'h003, 9'h184, 9'h042, win(3, 16, smp_l, 1), win(8, 16, smp_r, 1));
        fmt(9'h003, 9'h104, 9'h042, win(3, 16, smp_l, 1) & ~(32'h80000000 >> 19),
            win(8, 16, smp_r, 1) & ~(32'h80000000 >> 24));
        reg_wr(7'h25, 9'h004);
        fmt(9'h003, 9'h120, 9'h042, win(3, 8, 24'h210000, 1),
            win(8, 8, 24'ha10000, 1));
        reg_wr(7'h25, 9'h006);
        fmt(9'h003, 9'h120, 9'h042, win(3, 8, 24'h3b0000, 1),
            win(8, 8, 24'hbb0000, 1));
        check(32'({bclk_oe, fs_oe}), 32'h0);
        final_report();
    end
endmodule // asp_serial_port_bench
